// ===== include/pcu_pkg.sv
// Shared constants and types of the power control unit
package pcu_pkg;
  // ==========================================================
  // Widths
  // ==========================================================
  localparam int TMR_W = 16;      // Timer reload and count width
  localparam int DUTY_W = 8;      // Throttle period counter width
  localparam int PLANE_W = 4;     // Number of switchable power planes
  localparam int IDLE_N = 3;      // Doze, standby, suspend timers
  localparam int CAUSE_W = 5;     // Interrupt cause bits

  // ==========================================================
  // Interrupt cause bit positions
  // ==========================================================
  localparam int CAUSE_DOZE = 0;
  localparam int CAUSE_STANDBY = 1;
  localparam int CAUSE_SUSPEND = 2;
  localparam int CAUSE_WAKE = 3;
  localparam int CAUSE_PERIPH = 4;

  // ==========================================================
  // Values after reset
  // ==========================================================
  localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;
  localparam logic [DUTY_W-1:0] DUTY_RST = 8'h00;
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 5'h00;
  localparam logic [PLANE_W-1:0] PLANE_RST = 4'h0;

  // ==========================================================
  // Power states, deeper state saves more power
  // ==========================================================
  typedef enum logic [3:0] {
    PCU_ON = 4'h1,
    PCU_DOZE = 4'h2,
    PCU_STANDBY = 4'h4,
    PCU_SUSPEND = 4'h8
  } pcu_state_t;
endpackage

// ===== rtl/pcu_timer.sv
// Reloadable down-counting inactivity timer
`timescale 1ns/1ps
`default_nettype none
module pcu_timer import pcu_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic enable,
  input wire logic restart,
  input wire logic [TMR_W-1:0] load,
  // Status
  output logic expired,
  output logic [TMR_W-1:0] count
);
  logic [TMR_W-1:0] count_r;  // Remaining idle cycles
  logic expired_r;            // One-cycle expiry pulse

  // ==========================================================
  // Countdown
  // ==========================================================
  // Reload while disabled or on activity; zero load never fires
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= TMR_RST;
    end else if (!enable || restart) begin
      count_r <= load;
    end else if (count_r != TMR_RST) begin
      count_r <= count_r - 16'h0001;
    end
  end

  // Pulse on the step from one to zero only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      expired_r <= 1'b0;
    end else begin
      expired_r <= enable && !restart && (count_r == 16'h0001);
    end
  end

  assign expired = expired_r;
  assign count = count_r;
endmodule
`default_nettype wire

// ===== rtl/pcu_core.sv
// Power control unit: idle timers, power states, halt modulation
`timescale 1ns/1ps
`default_nettype none
// Function
// - Three idle timers: doze, standby, suspend
// - Idle timer expiry raises management interrupt
// - Activity in low-power state raises interrupt
// - Housekeeping timer absorbs bursts in doze/standby
// - Peripheral idle timer flags inactivity
// - Halt modulation throttles in every state but suspend, which holds the halt
// - Outputs switch off board power planes
// - Three power-down states, deeper after longer idle
// - Core halts only after finishing pending work
// - Internal clocks stop during suspend
// - Resume continues where it stopped
module pcu_core import pcu_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Activity detectors, same clock domain
  input wire logic sys_activity,
  input wire logic hk_activity,
  input wire logic periph_activity,
  // Timer setup
  input wire logic [IDLE_N-1:0] idle_en,
  input wire logic [TMR_W-1:0] doze_load,
  input wire logic [TMR_W-1:0] standby_load,
  input wire logic [TMR_W-1:0] suspend_load,
  input wire logic [TMR_W-1:0] hk_load,
  input wire logic periph_en,
  input wire logic [TMR_W-1:0] periph_load,
  // Management mode software control
  input wire logic state_wr,
  input wire logic [3:0] state_req,
  input wire logic [CAUSE_W-1:0] cause_en,
  input wire logic [CAUSE_W-1:0] cause_clr,
  // Throttle setup
  input wire logic throttle_en,
  input wire logic [DUTY_W-1:0] throttle_period,
  input wire logic [DUTY_W-1:0] throttle_halt,
  // Plane masks per state
  input wire logic [PLANE_W-1:0] plane_mask_standby,
  input wire logic [PLANE_W-1:0] plane_mask_suspend,
  // Processor core
  input wire logic cpu_halt_ack,
  output logic mgmt_interrupt,
  output logic cpu_halt_modulation_b,
  output logic core_clk_en,
  // Board and status
  output logic [PLANE_W-1:0] plane_off,
  output logic [3:0] power_state,
  output logic [CAUSE_W-1:0] cause,
  output logic hk_busy
);
  // ==========================================================
  // Declarations
  // ==========================================================
  pcu_state_t state_r;                   // Current power state
  logic [CAUSE_W-1:0] cause_r;           // Sticky interrupt causes
  logic [CAUSE_W-1:0] cause_set;         // Cause events this cycle
  logic irq_r;                           // Registered interrupt
  logic hk_busy_r;                       // Housekeeping burst open
  logic [DUTY_W-1:0] phase_r;            // Throttle phase counter
  logic halt_b_r;                        // Registered halt, low active
  logic clk_en_r;                        // Core clock enable
  logic [PLANE_W-1:0] plane_r;           // Plane switch-off
  logic [IDLE_N-1:0] idle_exp;           // Idle timer expiry pulses
  logic [TMR_W-1:0] idle_load [IDLE_N];  // Idle reload values
  logic [TMR_W-1:0] idle_cnt [IDLE_N];   // Idle counts
  logic hk_exp;                          // Housekeeping expiry
  logic periph_exp;                      // Peripheral expiry
  logic low_power;                       // Any power-down state
  logic hk_window;                       // Doze or standby
  logic halt_req;                        // Halt wanted this cycle

  assign idle_load[0] = doze_load;
  assign idle_load[1] = standby_load;
  assign idle_load[2] = suspend_load;
  assign low_power = (state_r != PCU_ON);
  assign hk_window = (state_r == PCU_DOZE) || (state_r == PCU_STANDBY);

  // ==========================================================
  // Timers
  // ==========================================================
  // Idle timers all restart on system activity
  for (genvar i = 0; i < IDLE_N; i++) begin : g_idle
    pcu_timer u_idle (
      .clk(clk),
      .rst_b(rst_b),
      .enable(idle_en[i]),
      .restart(sys_activity),
      .load(idle_load[i]),
      .expired(idle_exp[i]),
      .count(idle_cnt[i])
    );
  end

  // Housekeeping timer only counts in doze or standby
  pcu_timer u_hk (
    .clk(clk),
    .rst_b(rst_b),
    .enable(hk_window),
    .restart(hk_activity),
    .load(hk_load),
    .expired(hk_exp),
    .count()
  );

  // Peripheral timer is independent of system activity
  pcu_timer u_periph (
    .clk(clk),
    .rst_b(rst_b),
    .enable(periph_en),
    .restart(periph_activity),
    .load(periph_load),
    .expired(periph_exp),
    .count()
  );

  // ==========================================================
  // Interrupt causes
  // ==========================================================
  // Each idle timer expiry only counts from a shallower state, so deeper
  // states follow longer idle periods
  always_comb begin
    cause_set = CAUSE_RST;
    cause_set[CAUSE_DOZE] = idle_exp[0] && (state_r == PCU_ON);
    cause_set[CAUSE_STANDBY] = idle_exp[1] && ((state_r == PCU_ON) ||
                                              (state_r == PCU_DOZE));
    cause_set[CAUSE_SUSPEND] = idle_exp[2] && (state_r != PCU_SUSPEND);
    cause_set[CAUSE_WAKE] = sys_activity && low_power;
    cause_set[CAUSE_PERIPH] = periph_exp;
  end

  // Sticky causes; a new event beats a same-cycle clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cause_r <= CAUSE_RST;
    end else begin
      cause_r <= (cause_r & ~cause_clr) | cause_set;
    end
  end

  // Enabled causes drive the interrupt line
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(cause_r & cause_en);
    end
  end

  // ==========================================================
  // Power state
  // ==========================================================
  // Software moves the state; illegal codes are ignored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= PCU_ON;
    end else if (state_wr) begin
      case (state_req)
        PCU_ON: state_r <= PCU_ON;
        PCU_DOZE: state_r <= PCU_DOZE;
        PCU_STANDBY: state_r <= PCU_STANDBY;
        PCU_SUSPEND: state_r <= PCU_SUSPEND;
        default: state_r <= state_r;
      endcase
    end
  end

  // Housekeeping burst lifts throttling until its timer runs out
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hk_busy_r <= 1'b0;
    end else if (!hk_window) begin
      hk_busy_r <= 1'b0;
    end else if (hk_activity) begin
      hk_busy_r <= 1'b1;
    end else if (hk_exp) begin
      hk_busy_r <= 1'b0;
    end
  end

  // ==========================================================
  // Halt modulation
  // ==========================================================
  // Free-running phase over the programmed period
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= DUTY_RST;
    end else if (!throttle_en || (phase_r >= throttle_period)) begin
      phase_r <= DUTY_RST;
    end else begin
      phase_r <= phase_r + 8'h01;
    end
  end

  // Suspend holds the halt; else duty cycle in every state
  assign halt_req = (state_r == PCU_SUSPEND) ||
                    (throttle_en && !hk_busy_r && (phase_r < throttle_halt));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      halt_b_r <= 1'b1;
    end else begin
      halt_b_r <= !halt_req;
    end
  end

  // Clock stops only once the core reports its work drained;
  // leaving suspend restarts it on the next clock so no state is lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_en_r <= 1'b1;
    end else begin
      clk_en_r <= !((state_r == PCU_SUSPEND) && cpu_halt_ack);
    end
  end

  // ==========================================================
  // Power planes
  // ==========================================================
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      plane_r <= PLANE_RST;
    end else if (state_r == PCU_SUSPEND) begin
      plane_r <= plane_mask_suspend;
    end else if (state_r == PCU_STANDBY) begin
      plane_r <= plane_mask_standby;
    end else begin
      plane_r <= PLANE_RST;
    end
  end

  assign mgmt_interrupt = irq_r;
  assign cpu_halt_modulation_b = halt_b_r;
  assign core_clk_en = clk_en_r;
  assign plane_off = plane_r;
  assign power_state = state_r;
  assign cause = cause_r;
  assign hk_busy = hk_busy_r;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_in_suspend;
    state_r == PCU_SUSPEND;
  endsequence
  sequence s_drained;
    s_in_suspend ##0 cpu_halt_ack;
  endsequence

  AST_IDLE_RELOAD: assert property (sys_activity && (&idle_en) |=>
    idle_cnt[0] == $past(doze_load) && idle_cnt[1] == $past(standby_load)
    && idle_cnt[2] == $past(suspend_load))
    else $error("idle timers not reloaded on activity");
  AST_DOZE_IRQ: assert property (idle_exp[0] && state_r == PCU_ON &&
    cause_en[CAUSE_DOZE] |-> ##2 mgmt_interrupt)
    else $error("doze expiry gave no interrupt");
  AST_WAKE: assert property (sys_activity && low_power |=> cause_r[CAUSE_WAKE])
    else $error("activity in power-down not flagged");
  AST_SET_WINS: assert property (cause_set[CAUSE_PERIPH] && cause_clr[CAUSE_PERIPH]
    |=> cause_r[CAUSE_PERIPH])
    else $error("cause lost to clear");
  AST_HK_BUSY: assert property (hk_activity && hk_window |=> hk_busy_r)
    else $error("housekeeping burst not absorbed");
  AST_NO_DEEP_SKIP: assert property (idle_exp[0] && state_r != PCU_ON
    && !cause_r[CAUSE_DOZE] |=> !cause_r[CAUSE_DOZE])
    else $error("doze cause outside on state");
  AST_CPU_HALT_MODULATION_HALT: assert property (s_in_suspend |=> !cpu_halt_modulation_b)
    else $error("halt not held in suspend");
  AST_THROTTLE: assert property (throttle_en && !hk_busy_r && phase_r < throttle_halt
    |=> !cpu_halt_modulation_b)
    else $error("throttle phase not halting");
  AST_CLK_WAIT: assert property (s_in_suspend ##0 !cpu_halt_ack ##1 1'b1 |->
    core_clk_en)
    else $error("clock stopped before core drained");
  AST_CLK_STOP: assert property (s_drained |=> !core_clk_en)
    else $error("clock runs in suspend");
  AST_RESUME: assert property (state_r != PCU_SUSPEND |=> core_clk_en)
    else $error("clock not restored after suspend");
  AST_PLANE: assert property (s_in_suspend |=> plane_off == $past(plane_mask_suspend))
    else $error("suspend plane mask not applied");
endmodule
`default_nettype wire

// ===== sim/pcu_cpu_model.sv
// Behavioural model of the processor core behind the halt handshake
`timescale 1ns/1ps
`default_nettype none
module pcu_cpu_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Halt control from the power unit
  input wire logic cpu_halt_modulation_b,
  input wire logic core_clk_en,
  input wire logic [3:0] drain_len,
  // Handshake and progress
  output logic cpu_halt_ack,
  output logic [15:0] retired
);
  // ==========================================================
  // Core state
  // ==========================================================
  logic [3:0] pend_r;   // Decoded work still to finish
  logic ack_r;          // Drained and ready to stop
  logic [15:0] ret_r;   // Work retired, kept across a halt
  assign cpu_halt_ack = ack_r;
  assign retired = ret_r;

  // Run, drain pending work, then acknowledge
  // Nothing moves while clocks are stopped, so progress shows any loss
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_r <= 4'h0;
      ack_r <= 1'b0;
      ret_r <= 16'h0000;
    end else if (core_clk_en) begin
      if (cpu_halt_modulation_b) begin
        // Running: pending work set to drain_len
        ack_r <= 1'b0;
        ret_r <= ret_r + 16'h0001;
        pend_r <= drain_len;
      end else if (pend_r != 4'h0) begin
        // Halt asked: finish what was decoded
        pend_r <= pend_r - 4'h1;
        ret_r <= ret_r + 16'h0001;
      end else begin
        ack_r <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/pcu_core_tb.sv
// Self-checking testbench of the power control unit core
`timescale 1ns/1ps
`default_nettype none
module pcu_core_tb import pcu_pkg::*;;
  // ==========================================================
  // Stimulus and observed signals
  // ==========================================================
  logic clk, rst_b, sys_act, hk_act, per_act, per_en, st_wr, thr_en, ack;
  logic mgmt_irq, halt_b, clk_en, hk_busy;
  logic [IDLE_N-1:0] idle_en;
  logic [TMR_W-1:0] ld_doze, ld_sb, ld_su, ld_hk, ld_per;
  logic [3:0] st_req, pwr, drain;
  logic [CAUSE_W-1:0] cause_en, cause_clr, cause;
  logic [DUTY_W-1:0] thr_per, thr_halt;
  logic [PLANE_W-1:0] planes;
  logic [15:0] retired, r0;
  int errors, checked, n, lows;
  typedef struct packed {logic [3:0] req; logic [3:0] st; logic [3:0] pl;} pcu_row_t;
  pcu_row_t rows[6] = '{'{4'h2, 4'h2, 4'h0}, '{4'h4, 4'h4, 4'h5}, '{4'h8, 4'h8, 4'hA},
                        '{4'h3, 4'h8, 4'hA}, '{4'h4, 4'h4, 4'h5}, '{4'h1, 4'h1, 4'h0}};
  logic [TMR_W-1:0] loads[3] = '{16'h0005, 16'h0008, 16'h000C};

  pcu_core i_dut (.clk(clk), .rst_b(rst_b), .sys_activity(sys_act), .hk_activity(hk_act),
    .periph_activity(per_act), .idle_en(idle_en), .doze_load(ld_doze),
    .standby_load(ld_sb), .suspend_load(ld_su), .hk_load(ld_hk), .periph_en(per_en),
    .periph_load(ld_per), .state_wr(st_wr), .state_req(st_req), .cause_en(cause_en),
    .cause_clr(cause_clr), .throttle_en(thr_en), .throttle_period(thr_per),
    .throttle_halt(thr_halt), .plane_mask_standby(4'h5), .plane_mask_suspend(4'hA),
    .cpu_halt_ack(ack), .mgmt_interrupt(mgmt_irq), .cpu_halt_modulation_b(halt_b),
    .core_clk_en(clk_en), .plane_off(planes), .power_state(pwr), .cause(cause),
    .hk_busy(hk_busy));
  pcu_cpu_model i_cpu (.clk(clk), .rst_b(rst_b), .cpu_halt_modulation_b(halt_b),
    .core_clk_en(clk_en), .drain_len(drain), .cpu_halt_ack(ack), .retired(retired));

  // ==========================================================
  // Clock, watchdog and shared tasks
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run is well under 1000 cycles
  initial begin
    #50000;
    errors++;
    $display("mismatch watchdog expected done seen timeout");
    results();
  end
  task automatic results;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // One-cycle state write, returns once plane outputs settled
  task automatic go(input logic [3:0] s);
    st_wr = 1'b1;
    st_req = s;
    cyc(1);
    st_wr = 1'b0;
    cyc(2);
  endtask
  task automatic clr;
    cause_clr = 5'h1F;
    cyc(1);
    cause_clr = 5'h00;
  endtask
  task automatic pulse_sys;
    sys_act = 1'b1;
    cyc(1);
    sys_act = 1'b0;
  endtask
  // Bounded wait for one cause bit
  task automatic wait_cause(input int i, output int k);
    k = 0;
    while (cause[i] !== 1'b1 && k < 40) begin
      cyc(1);
      k++;
    end
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    errors = 0; checked = 0; rst_b = 1'b0; sys_act = 1'b0; hk_act = 1'b0;
    per_act = 1'b0; per_en = 1'b0; st_wr = 1'b0; st_req = 4'h1; thr_en = 1'b0;
    idle_en = 3'h0; ld_doze = 16'h0005; ld_sb = 16'h0008; ld_su = 16'h000C;
    ld_hk = 16'h0006; ld_per = 16'h0006; cause_en = 5'h1F; cause_clr = 5'h00;
    thr_per = 8'h03; thr_halt = 8'h02; drain = 4'h0;
    cyc(10);
    // Power state ON is code 1 in the top nibble of this 17-bit word
    chk("reset outs", {pwr, planes, cause, mgmt_irq, halt_b, clk_en, hk_busy}, 17'h02006);
    $display("test reset done");
    rst_b = 1'b1;
    cyc(1);
    // Ordinary state writes, prompt core, illegal code ignored
    foreach (rows[i]) begin
      go(rows[i].req);
      chk("power_state", rows[i].st, pwr);
      chk("plane_off", rows[i].pl, planes);
    end
    $display("test state table done");
    // Activity keeps restarting every idle timer
    idle_en = 3'h7;
    clr();
    repeat (10) begin
      pulse_sys();
      cyc(2);
    end
    chk("cause under activity", 5'h00, cause);
    $display("test activity restart done");
    // Each timer alone, deeper ones take longer
    for (int i = 0; i < 3; i++) begin
      idle_en = 3'h1 << i;
      pulse_sys();
      clr();
      wait_cause(i, n);
      chk("idle expiry window", 1, n >= loads[i] - 2 && n <= loads[i] + 4);
      chk("idle cause", 5'h01 << i, cause);
      cyc(1);
      chk("irq on expiry", 1, mgmt_irq);
    end
    idle_en = 3'h0;
    $display("test idle timers done");
    // Wake from doze, then housekeeping burst
    go(4'h2);
    clr();
    pulse_sys();
    chk("wake cause", 5'h08, cause);
    cyc(1);
    chk("wake irq", 1, mgmt_irq);
    clr();
    chk("cause cleared", 5'h00, cause);
    hk_act = 1'b1;
    cyc(1);
    hk_act = 1'b0;
    chk("hk open", 1, hk_busy);
    chk("hk stays dozing", 4'h2, pwr);
    cyc(10);
    chk("hk closed", 0, hk_busy);
    // Doze timer expiry while already dozing must not be recorded
    idle_en = 3'h1;
    cyc(9);
    chk("no doze cause while dozing", 5'h00, cause);
    idle_en = 3'h0;
    $display("test wake and housekeeping done");
    // Throttle duty: 2 of every 4 cycles, in doze and on
    thr_en = 1'b1;
    for (int s = 0; s < 2; s++) begin
      go(s == 0 ? 4'h2 : 4'h1);
      cyc(4);
      lows = 0;
      repeat (8) begin
        cyc(1);
        lows += (halt_b === 1'b0);
      end
      chk("halt low cycles", 4, lows);
    end
    thr_en = 1'b0;
    $display("test throttle done");
    // Peripheral idle timer
    per_en = 1'b1;
    per_act = 1'b1;
    cyc(1);
    per_act = 1'b0;
    clr();
    wait_cause(CAUSE_PERIPH, n);
    chk("periph window", 1, n >= 4 && n <= 10);
    // Clear held across the expiry cycle: the new event must survive
    per_act = 1'b1;
    cyc(1);
    per_act = 1'b0;
    cause_clr = 5'h10;
    cyc(7);
    cause_clr = 5'h00;
    chk("periph set beats clear", 1, cause[CAUSE_PERIPH]);
    per_en = 1'b0;
    $display("test peripheral done");
    // Suspend with slow drain, clocks stop, resume where stopped
    drain = 4'h5;
    go(4'h8);
    chk("clock before drain", 1, clk_en);
    n = 0;
    while (clk_en !== 1'b0 && n < 20) begin
      cyc(1);
      n++;
    end
    chk("drain before stop", 1, n >= 5 && n < 20);
    r0 = retired;
    cyc(5);
    chk("frozen core", r0, retired);
    go(4'h1);
    chk("clock back", 2'b11, {clk_en, halt_b});
    cyc(3);
    chk("resumed progress", 1, retired > r0 && retired <= r0 + 16'h0005);
    $display("test suspend done");
    // Reset in mid-run from standby
    go(4'h4);
    rst_b = 1'b0;
    cyc(1);
    chk("mid reset", {pwr, planes, cause, mgmt_irq, halt_b, clk_en, hk_busy}, 17'h02006);
    rst_b = 1'b1;
    cyc(2);
    $display("test mid reset done");
    results();
  end
endmodule
`default_nettype wire
